// ===== logic/aptp_control.v
// converter trigger, pacer, result and interrupt control
//
// Contract
// - software trigger write starts one conversion; result lands at offsets 4 and 5
// - result is 12-bit unsigned, 0 to 4095, split over low and high bytes
// - pollable data-ready bit goes low when a result is available
// - interrupt request status holds until host clears it; no new interrupt meanwhile
// - pacer is two cascaded 16-bit dividers; rate set by their product
// - any divider loaded as zero stops pacer triggers
// - mode field picks trigger source and polling or interrupt, six modes
// - channel register picks one of eight inputs, resets to channel 0
// - range register picks gain 1,2,4,8,16; resets to gain 1 bipolar
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "aptp_defs.vh"
module aptp_control (
    input wire clk,
    input wire rst,
    input wire [`APTP_AW-1:0] regAddr,
    input wire [`APTP_DW-1:0] regWrData,
    input wire regWrStb,
    input wire regRdStb,
    output reg [`APTP_DW-1:0] regRdData,
    output wire irq,
    input wire extTrig,
    output reg adcStart,
    output reg [`APTP_CH_W-1:0] adcChannel,
    output reg [`APTP_GAIN_W-1:0] adcGain,
    output reg adcUnipolar,
    input wire adcDone,
    input wire [`APTP_RES_W-1:0] adcData
);
    // mode decoding: upper bits give the source, bit 0 the transfer kind
    function [1:0] modeSource;
        input [`APTP_MODE_W-1:0] m;
        begin
            modeSource = m[2:1];
        end
    endfunction

    function modeIsIrq;
        input [`APTP_MODE_W-1:0] m;
        begin
            modeIsIrq = m[0];
        end
    endfunction

    function regHit;
        input [`APTP_AW-1:0] a;
        input [`APTP_AW-1:0] target;
        input stb;
        begin
            regHit = stb && (a == target);
        end
    endfunction

    // a divider loaded with zero never paces
    function divLive;
        input [`APTP_DIV_W-1:0] d;
        begin
            divLive = (d != {`APTP_DIV_W{1'b0}});
        end
    endfunction

    reg [`APTP_DIV_W-1:0] div1_q;
    reg [`APTP_DIV_W-1:0] div2_q;
    reg [`APTP_MODE_W-1:0] mode_q;
    reg [`APTP_IRQ_W-1:0] irqStat_q;
    reg [`APTP_IRQ_W-1:0] irqStat_d;
    reg [`APTP_IRQ_W-1:0] irqMask_q;
    reg [`APTP_RES_W-1:0] result_q;
    reg ready_q;
    reg busy_q;
    reg extTrigPrev_q;
    reg [`APTP_DIV_W-1:0] convCount_q;
    reg [`APTP_DW-1:0] rdNext;

    wire [1:0] source = modeSource(mode_q);
    wire irqMode = modeIsIrq(mode_q);

    wire wrT1Lo = regHit(regAddr, `APTP_A_T1_LO, regWrStb);
    wire wrT1Hi = regHit(regAddr, `APTP_A_T1_HI, regWrStb);
    wire wrT2Lo = regHit(regAddr, `APTP_A_T2_LO, regWrStb);
    wire wrT2Hi = regHit(regAddr, `APTP_A_T2_HI, regWrStb);
    wire wrMask = regHit(regAddr, `APTP_A_IRQ_MASK, regWrStb);
    wire wrChan = regHit(regAddr, `APTP_A_CHANNEL, regWrStb);
    wire wrRange = regHit(regAddr, `APTP_A_RANGE, regWrStb);
    wire wrMode = regHit(regAddr, `APTP_A_MODE, regWrStb);
    wire wrSwTrig = regHit(regAddr, `APTP_A_SW_TRIG, regWrStb);
    wire wrIrqClr = regHit(regAddr, `APTP_A_IRQ_CLR, regWrStb);
    wire rdResHi = regHit(regAddr, `APTP_A_RES_HI, regRdStb);
    wire rdIrqStat = regHit(regAddr, `APTP_A_IRQ_STAT, regRdStb);

    // host registers
    always @(posedge clk) begin
        if (rst) begin
            div1_q <= {`APTP_DIV_W{1'b0}};
            div2_q <= {`APTP_DIV_W{1'b0}};
            mode_q <= `APTP_MODE_RST;
            irqMask_q <= {`APTP_IRQ_W{1'b0}};
            adcChannel <= `APTP_CH_RST;
            adcGain <= `APTP_GAIN_RST;
            adcUnipolar <= 1'b0;
        end else begin
            if (wrT1Lo) begin
                div1_q[7:0] <= regWrData;
            end
            if (wrT1Hi) begin
                div1_q[15:8] <= regWrData;
            end
            if (wrT2Lo) begin
                div2_q[7:0] <= regWrData;
            end
            if (wrT2Hi) begin
                div2_q[15:8] <= regWrData;
            end
            if (wrMask) begin
                irqMask_q <= regWrData[`APTP_IRQ_W-1:0];
            end
            if (wrChan) begin
                adcChannel <= regWrData[`APTP_CH_W-1:0];
            end
            // codes past x16 are dropped so the amplifier never sees a bad code
            if (wrRange) begin
                if (regWrData[`APTP_GAIN_W-1:0] <= `APTP_GAIN_MAX) begin
                    adcGain <= regWrData[`APTP_GAIN_W-1:0];
                end
                adcUnipolar <= regWrData[`APTP_RANGE_UNI];
            end
            // only the six defined modes are accepted
            if (wrMode && regWrData[`APTP_MODE_W-1:0] <= `APTP_MODE_MAX) begin
                mode_q <= regWrData[`APTP_MODE_W-1:0];
            end
        end
    end

    // pacer: divider 1 counts clocks, divider 2 counts divider 1 ticks
    wire pacerRun = (source == `APTP_SRC_TIMER);
    // reload a cycle after the write, so the counters load the new byte and not the old one
    reg divReload_q;
    always @(posedge clk) begin
        if (rst) begin
            divReload_q <= 1'b0;
        end else begin
            divReload_q <= wrT1Lo || wrT1Hi || wrT2Lo || wrT2Hi || wrMode;
        end
    end
    wire tick1;
    wire tick2;

    aptp_divider u_div1 (
        .clk(clk),
        .rst(rst),
        .step(pacerRun),
        .reload(divReload_q),
        .divisor(div1_q),
        .tick(tick1)
    );

    aptp_divider u_div2 (
        .clk(clk),
        .rst(rst),
        .step(pacerRun && tick1),
        .reload(divReload_q),
        .divisor(div2_q),
        .tick(tick2)
    );

    // zero in either divider silences the pacer outright
    wire pacerTrig = tick2 && pacerRun && divLive(div1_q) && divLive(div2_q);

    // trigger selection
    wire swTrig = wrSwTrig && (source == `APTP_SRC_SW);
    wire extRise = extTrig && !extTrigPrev_q && (source == `APTP_SRC_EXT);
    wire trigReq = swTrig || extRise || pacerTrig;
    wire trigAccept = trigReq && !busy_q;
    wire trigLost = trigReq && busy_q;

    always @(posedge clk) begin
        if (rst) begin
            extTrigPrev_q <= 1'b0;
            adcStart <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            extTrigPrev_q <= extTrig;
            // start is a single cycle per accepted trigger
            adcStart <= trigAccept;
            if (trigAccept) begin
                busy_q <= 1'b1;
            end else if (adcDone) begin
                busy_q <= 1'b0;
            end
        end
    end

    // result capture and data-ready
    always @(posedge clk) begin
        if (rst) begin
            result_q <= {`APTP_RES_W{1'b0}};
            ready_q <= 1'b0;
            convCount_q <= {`APTP_DIV_W{1'b0}};
        end else begin
            if (adcDone && busy_q) begin
                result_q <= adcData;
                convCount_q <= convCount_q + {{(`APTP_DIV_W-1){1'b0}}, 1'b1};
            end
            // a new result wins over the high-byte read in the same cycle
            if (adcDone && busy_q) begin
                ready_q <= 1'b1;
            end else if (rdResHi) begin
                ready_q <= 1'b0;
            end
        end
    end

    // sticky interrupt status: a set always wins over a clear
    always @* begin
        irqStat_d = irqStat_q;
        if (rdIrqStat || wrIrqClr) begin
            irqStat_d = {`APTP_IRQ_W{1'b0}};
        end
        if (adcDone && busy_q && irqMode) begin
            irqStat_d[`APTP_IRQ_DONE] = 1'b1;
        end
        if (trigLost) begin
            irqStat_d[`APTP_IRQ_LOST] = 1'b1;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            irqStat_q <= {`APTP_IRQ_W{1'b0}};
        end else begin
            irqStat_q <= irqStat_d;
        end
    end

    // level request stays up until the status is cleared
    assign irq = |(irqStat_q & irqMask_q);

    // read mux; unmapped or write-only locations read zero
    always @* begin
        rdNext = {`APTP_DW{1'b0}};
        case (regAddr)
            `APTP_A_T1_LO: rdNext = div1_q[7:0];
            `APTP_A_T1_HI: rdNext = div1_q[15:8];
            `APTP_A_T2_LO: rdNext = div2_q[7:0];
            `APTP_A_T2_HI: rdNext = div2_q[15:8];
            `APTP_A_RES_LO: rdNext = result_q[7:0];
            `APTP_A_RES_HI: rdNext = {4'h0, result_q[11:8]};
            `APTP_A_STATUS: begin
                rdNext[`APTP_ST_READY_N] = ~ready_q;
                rdNext[`APTP_ST_BUSY] = busy_q;
                rdNext[`APTP_ST_IRQ] = irq;
            end
            `APTP_A_IRQ_STAT: rdNext[`APTP_IRQ_W-1:0] = irqStat_q;
            `APTP_A_IRQ_MASK: rdNext[`APTP_IRQ_W-1:0] = irqMask_q;
            `APTP_A_CHANNEL: rdNext[`APTP_CH_W-1:0] = adcChannel;
            `APTP_A_RANGE: rdNext = {4'h0, adcUnipolar, adcGain};
            `APTP_A_MODE: rdNext[`APTP_MODE_W-1:0] = mode_q;
            `APTP_A_CNT_LO: rdNext = convCount_q[7:0];
            `APTP_A_CNT_HI: rdNext = convCount_q[15:8];
            default: rdNext = {`APTP_DW{1'b0}};
        endcase
    end

    // read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (rst) begin
            regRdData <= {`APTP_DW{1'b0}};
        end else if (regRdStb) begin
            regRdData <= rdNext;
        end else begin
            regRdData <= {`APTP_DW{1'b0}};
        end
    end
endmodule // aptp_control
`default_nettype wire

// ===== logic/aptp_defs.vh
// register map, field positions, reset values and mode codes
`ifndef APTP_DEFS_VH
`define APTP_DEFS_VH

`define APTP_AW 4
`define APTP_DW 8
`define APTP_RES_W 12
`define APTP_DIV_W 16

`define APTP_A_T1_LO 4'h0
`define APTP_A_T1_HI 4'h1
`define APTP_A_T2_LO 4'h2
`define APTP_A_T2_HI 4'h3
`define APTP_A_RES_LO 4'h4
`define APTP_A_RES_HI 4'h5
`define APTP_A_STATUS 4'h6
`define APTP_A_IRQ_STAT 4'h7
`define APTP_A_IRQ_MASK 4'h8
`define APTP_A_CHANNEL 4'h9
`define APTP_A_RANGE 4'ha
`define APTP_A_MODE 4'hb
`define APTP_A_SW_TRIG 4'hc
`define APTP_A_IRQ_CLR 4'hd
`define APTP_A_CNT_LO 4'he
`define APTP_A_CNT_HI 4'hf

`define APTP_ST_READY_N 0
`define APTP_ST_BUSY 1
`define APTP_ST_IRQ 2

`define APTP_IRQ_DONE 0
`define APTP_IRQ_LOST 1
`define APTP_IRQ_W 2

`define APTP_RANGE_UNI 3
`define APTP_GAIN_W 3
`define APTP_GAIN_MAX 3'h4
`define APTP_GAIN_RST 3'h0
`define APTP_CH_W 3
`define APTP_CH_RST 3'h0

`define APTP_MODE_W 3
`define APTP_MODE_RST 3'h0
`define APTP_MODE_MAX 3'h5
`define APTP_SRC_SW 2'h0
`define APTP_SRC_EXT 2'h1
`define APTP_SRC_TIMER 2'h2

`endif

// ===== logic/aptp_divider.v
// one 16-bit reloading frequency divider of the pacer
`timescale 1ns/100ps
`default_nettype none
`include "aptp_defs.vh"
module aptp_divider (
    input wire clk,
    input wire rst,
    input wire step,
    input wire reload,
    input wire [`APTP_DIV_W-1:0] divisor,
    output reg tick
);
    reg [`APTP_DIV_W-1:0] count_q;
    wire zeroDiv = (divisor == {`APTP_DIV_W{1'b0}});

    always @(posedge clk) begin
        if (rst || reload) begin
            count_q <= divisor;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            // a zero divisor never reaches terminal count
            if (step && !zeroDiv) begin
                if (count_q <= {{(`APTP_DIV_W-1){1'b0}}, 1'b1}) begin
                    count_q <= divisor;
                    tick <= 1'b1;
                end else begin
                    count_q <= count_q - {{(`APTP_DIV_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // aptp_divider
`default_nettype wire

// ===== tb/aptp_control_assertions.sv
// port-level checker for the converter control block
`timescale 1ns/100ps
`default_nettype none
module aptp_control_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [7:0] regRdData,
    input wire logic irq,
    input wire logic adcStart,
    input wire logic [2:0] adcChannel,
    input wire logic [2:0] adcGain,
    input wire logic adcUnipolar,
    input wire logic adcDone
);
    logic busyQ;
    logic [2:0] modeQ;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // shadow state: busy sets one cycle after the design's and clears on the same adcDone, so adcStart stands in for it
    always @(posedge clk) begin
        if (rst) begin
            busyQ <= 1'b0;
            modeQ <= 3'h0;
        end else begin
            busyQ <= adcStart | (busyQ & ~adcDone);
            if (regWrStb && regAddr == 4'hb && regWrData[2:0] <= 3'h5) modeQ <= regWrData[2:0];
        end
    end
    property p_startPulse; adcStart |=> !adcStart; endproperty
    a_startPulse: assert property (p_startPulse) else $error("start pulse too long");
    property p_busyNoStart; busyQ |-> !adcStart; endproperty
    a_busyNoStart: assert property (p_busyNoStart) else $error("start while busy");
    property p_swTrig;
        regWrStb && regAddr == 4'hc && modeQ < 3'h2 && !busyQ && !adcStart |=> adcStart;
    endproperty
    a_swTrig: assert property (p_swTrig) else $error("no start after trigger");
    property p_rdIdle; !$past(regRdStb) |-> regRdData == 8'h00; endproperty
    a_rdIdle: assert property (p_rdIdle) else $error("read data outside slot");
    property p_chan; regWrStb && regAddr == 4'h9 |=> adcChannel == $past(regWrData[2:0]); endproperty
    a_chan: assert property (p_chan) else $error("channel not taken");
    property p_gainOk;
        regWrStb && regAddr == 4'ha && regWrData[2:0] <= 3'h4 |=>
            adcGain == $past(regWrData[2:0]) && adcUnipolar == $past(regWrData[3]);
    endproperty
    a_gainOk: assert property (p_gainOk) else $error("range not taken");
    property p_gainBad;
        regWrStb && regAddr == 4'ha && regWrData[2:0] > 3'h4 |=>
            $stable(adcGain) && adcUnipolar == $past(regWrData[3]);
    endproperty
    a_gainBad: assert property (p_gainBad) else $error("bad gain taken");
    property p_gainMax; adcGain <= 3'h4; endproperty
    a_gainMax: assert property (p_gainMax) else $error("gain code out of range");
    c_start: cover property (adcStart);
    c_irq: cover property (irq);
    c_gainBad: cover property (regWrStb && regAddr == 4'ha && regWrData[2:0] > 3'h4);
endmodule // aptp_control_assertions
bind aptp_control aptp_control_assertions u_chk (.clk, .rst, .regAddr, .regWrData, .regWrStb,
    .regRdStb, .regRdData, .irq, .adcStart, .adcChannel, .adcGain, .adcUnipolar, .adcDone);
`default_nettype wire

// ===== tb/aptp_adc_model.sv
// behavioural converter answering each start pulse after a fixed latency
`timescale 1ns/100ps
`default_nettype none
module aptp_adc_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic adcStart,
    input wire logic [3:0] lat,
    input wire logic [11:0] value,
    output logic adcDone,
    output logic [11:0] adcData
);
    logic [3:0] cnt;
    always @(posedge clk) begin
        if (rst) begin
            cnt <= 4'h0;
            adcDone <= 1'b0;
            adcData <= 12'h000;
        end else begin
            adcDone <= (cnt == 4'h1);
            // data only means something beside adcDone, so it toggles elsewhere
            adcData <= (cnt == 4'h1) ? value : ~adcData;
            if (adcStart) cnt <= lat;
            else if (cnt != 4'h0) cnt <= cnt - 4'h1;
        end
    end
endmodule // aptp_adc_model
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    typedef struct {logic [3:0] a; logic [7:0] w; logic [7:0] r;} aptp_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWrStb = 1'b0;
    logic regRdStb = 1'b0;
    logic extTrig = 1'b0;
    logic [11:0] adcValue = 12'hfff;
    wire [7:0] regRdData;
    wire irq, adcStart, adcUnipolar, adcDone;
    wire [2:0] adcChannel, adcGain;
    wire [11:0] adcData;
    int n_fail = 0;
    int n_checks = 0;
    int nStarts = 0;
    int n0 = 0;
    int cyc = 0;
    int lastStart = 0;
    int gap = 0;
    // gain code 5 is refused but the unipolar bit is still written
    aptp_row_t rows [8] = '{'{4'h9, 8'h07, 8'h07}, '{4'h9, 8'h00, 8'h00}, '{4'ha, 8'h0c, 8'h0c},
        '{4'ha, 8'h05, 8'h04}, '{4'hb, 8'h03, 8'h03}, '{4'hb, 8'h06, 8'h03},
        '{4'h0, 8'hff, 8'hff}, '{4'h3, 8'h80, 8'h80}};
    aptp_control DUT (.clk, .rst, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData, .irq,
        .extTrig, .adcStart, .adcChannel, .adcGain, .adcUnipolar, .adcDone, .adcData);
    aptp_adc_model u_adc (.clk, .rst, .adcStart, .lat(4'h5), .value(adcValue), .adcDone, .adcData);
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (adcStart === 1'b1) begin
            nStarts++;
            gap = cyc - lastStart;
            lastStart = cyc;
        end
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] w);
        @(posedge clk);
        regWrStb <= 1'b1;
        regAddr <= a;
        regWrData <= w;
        @(posedge clk);
        regWrStb <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdchk(input string n, input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        regRdStb <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRdStb <= 1'b0;
        #1 chk(n, e, regRdData);
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wait_irq;
        for (int i = 0; i < 200 && irq !== 1'b1; i++) @(posedge clk);
        if (irq !== 1'b1) begin
            chk("irqWait", 8'h01, {7'h0, irq});
            finish_test();
        end
    endtask
    initial begin
        #300000;
        n_fail++;
        finish_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rdchk("channel", 4'h9, 8'h00);
        rdchk("range", 4'ha, 8'h00);
        rdchk("mode", 4'hb, 8'h00);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rdchk("row", rows[i].a, rows[i].r);
        end
        chk("gainPort", 8'h04, {5'h0, adcGain});
        $display("test registers done");
        wr(4'h8, 8'h01);
        wr(4'hb, 8'h01);
        wr(4'hc, 8'h00);
        wr(4'hc, 8'h00);
        wait_irq();
        chk("starts", 8'h01, nStarts[7:0]);
        rdchk("status", 4'h6, 8'h04);
        rdchk("resLo", 4'h4, 8'hff);
        rdchk("resHi", 4'h5, 8'h0f);
        rdchk("status", 4'h6, 8'h05);
        repeat (20) @(posedge clk);
        chk("irqHeld", 8'h01, {7'h0, irq});
        rdchk("irqStat", 4'h7, 8'h03);
        chk("irqRead", 8'h00, {7'h0, irq});
        wr(4'hc, 8'h00);
        wait_irq();
        wr(4'hd, 8'h00);
        #1 chk("irqClr", 8'h00, {7'h0, irq});
        $display("test interrupt done");
        wr(4'hb, 8'h00);
        wr(4'hc, 8'h00);
        repeat (20) @(posedge clk);
        rdchk("pollStat", 4'h7, 8'h00);
        rdchk("pollReady", 4'h6, 8'h00);
        wr(4'hb, 8'h02);
        n0 = nStarts;
        wr(4'hc, 8'h00);
        extTrig <= 1'b1;
        repeat (10) @(posedge clk);
        extTrig <= 1'b0;
        chk("extStarts", n0[7:0] + 8'h01, nStarts[7:0]);
        $display("test modes done");
        wr(4'h0, 8'h08);
        wr(4'h1, 8'h00);
        wr(4'h2, 8'h09);
        wr(4'h3, 8'h00);
        wr(4'hb, 8'h04);
        repeat (200) @(posedge clk);
        chk("pacerGap", 8'h48, gap[7:0]);
        wr(4'h2, 8'h00);
        repeat (2) @(posedge clk);
        n0 = nStarts;
        repeat (150) @(posedge clk);
        chk("pacerOff", n0[7:0], nStarts[7:0]);
        $display("test pacer done");
        wr(4'hb, 8'h05);
        rdchk("runClr", 4'h7, 8'h00);
        n0 = nStarts;
        wr(4'h2, 8'h09);
        for (int k = 0; k < 3; k++) begin
            wait_irq();
            rdchk("runStat", 4'h7, 8'h01);
        end
        wr(4'hb, 8'h00);
        wr(4'h0, 8'h00);
        chk("runStarts", n0[7:0] + 8'h03, nStarts[7:0]);
        repeat (20) @(posedge clk);
        rdchk("cntLo", 4'he, nStarts[7:0]);
        rdchk("cntHi", 4'hf, 8'h00);
        $display("test paced interrupt done");
        wr(4'h9, 8'h05);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdchk("rstChan", 4'h9, 8'h00);
        rdchk("rstRange", 4'ha, 8'h00);
        rdchk("rstCnt", 4'he, 8'h00);
        $display("test mid reset done");
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
